// ==== logic/ertr_pkg.sv ====
// Purpose: shared constants and types of the event trigger routing block
// Assumes: 10 MHz mclk, 16-bit register words on a plain strobe port
// Notes:   register offsets are word indices on the local port
`default_nettype none

package ertr_pkg;

  // clock and timing grid
  localparam int unsigned CLK_KHZ  = 10000;
  localparam int unsigned GRID_NS  = 1000;
  // longest alignment time, so the cycle count rounds down
  localparam int unsigned GRID_CYC = (GRID_NS * CLK_KHZ) / 1000000;
  localparam int unsigned GRID_W   = 4;
  localparam logic [GRID_W-1:0] GRID_LAST = GRID_W'(GRID_CYC - 1);

  // channels
  localparam int unsigned NCHAN = 3;
  localparam int unsigned CH_ONE   = 0;
  localparam int unsigned CH_TWO   = 1;
  localparam int unsigned CH_THREE = 2;

  // register port
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] REG_STAT = 3'h1;
  localparam logic [ADDR_W-1:0] REG_MASK = 3'h2;
  localparam logic [ADDR_W-1:0] REG_BUF  = 3'h3;
  localparam logic [ADDR_W-1:0] REG_SW   = 3'h4;

  // sticky status bits, mask uses the same layout
  localparam int unsigned STAT_W    = 5;
  localparam int unsigned ST_ONE    = 0;
  localparam int unsigned ST_MODE   = 1;
  localparam int unsigned ST_AOVF   = 2;
  localparam int unsigned ST_TWO    = 3;
  localparam int unsigned ST_THREE  = 4;
  localparam logic [STAT_W-1:0] STAT_RST = 5'h00;
  localparam logic [STAT_W-1:0] MASK_RST = 5'h00;

  // switches
  localparam int unsigned ASW_W = 8;
  localparam int unsigned VSW_W = 5;
  localparam int unsigned SW_W  = ASW_W + VSW_W + 1;

  // rate selection that takes counts from a trigger channel
  localparam logic [2:0] RATE_EXT = 3'h6;

  typedef enum logic [1:0] {
    ERTR_MODE_SINGLE,
    ERTR_MODE_REPEAT,
    ERTR_MODE_EXT_TIME,
    ERTR_MODE_EXT_ZERO
  } ertr_mode_type;

  typedef struct packed {
    logic [1:0]    rsv_hi;
    logic          start_on_trig;
    logic [3:0]    rsv_mid;
    logic          auto_inc;
    logic [2:0]    rate_b;
    logic [2:0]    rate_a;
    ertr_mode_type mode;
  } ertr_ctrl_type;

  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ertr_bus_req_type;

endpackage

`default_nettype wire

// ==== logic/ertr_edge_chan.sv ====
// Purpose: one trigger channel, pin synchroniser and slope-selected edge
// Assumes: pin and slope line are asynchronous to mclk
// Notes:   output is one registered pulse per selected edge
`default_nettype none
`timescale 1ns/100ps

module ertr_edge_chan (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic trig_pin,
  input  wire logic slope_pin,
  output var  logic edge_pulse
);

  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_old_ff;
  logic slp_s1_ff;
  logic slp_s2_ff;
  logic pulse_ff;
  logic rise;
  logic fall;
  logic nxt_pulse;

  assign rise = pin_s2_ff & ~pin_old_ff;
  assign fall = ~pin_s2_ff & pin_old_ff;
  // slope low picks rising, open (pulled high) picks falling
  assign nxt_pulse = slp_s2_ff ? fall : rise;

  // synchronisers run through reset so they hold the idle level on
  // release; a zero preset would fake an edge on a pin that idles high
  always_ff @(posedge mclk) begin
    pin_s1_ff  <= trig_pin;
    pin_s2_ff  <= pin_s1_ff;
    pin_old_ff <= pin_s2_ff;
    slp_s1_ff  <= slope_pin;
    slp_s2_ff  <= slp_s1_ff;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= nxt_pulse;
    end
  end

  assign edge_pulse = pulse_ff;

endmodule

`default_nettype wire

// ==== logic/ertr_core.sv ====
// Purpose: routes three external trigger channels to clock A/B actions
// Assumes: counter cores sit outside; their value and overflow arrive
//          on mclk; switch and strap pins are static but asynchronous
// Notes:   alignment to the 1 us grid costs up to one grid period
`default_nettype none
`timescale 1ns/100ps

// Summary of operation
// - channel one event starts counter A when enabled
// - rate six counts A on channel one
// - channel one sets flag, may interrupt
// - align channel one, finer with auto-increment
// - raw channel one trigger driven out
// - modes two/three: channel two captures A, flags
// - align channel two, drive synced copy out
// - rate six counts B on channel three
// - slope low rising, open falling edge
// - address switch on is zero, vector one
// - strap fitted: overflow flags in every mode, may interrupt
// - mode three clears A after capture
// - mode flag with enable requests interrupt
module ertr_core (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire ertr_pkg::ertr_bus_req_type   bus_req,
  output var  logic [ertr_pkg::DATA_W-1:0]  bus_rdata,
  input  wire logic                         event_input_one,
  input  wire logic                         event_input_two,
  input  wire logic                         event_input_three,
  input  wire logic                         slope_one,
  input  wire logic                         slope_two,
  input  wire logic                         slope_three,
  input  wire logic [ertr_pkg::ASW_W-1:0]   addr_switch_on,
  input  wire logic [ertr_pkg::VSW_W-1:0]   vec_switch_on,
  input  wire logic                         overflow_irq_all_modes_strap,
  input  wire logic [ertr_pkg::DATA_W-1:0]  counter_a_value,
  input  wire logic                         counter_a_ovf,
  output var  logic                         trig_one_out,
  output var  logic                         trig_three_out,
  output var  logic                         synced_event_one,
  output var  logic                         synced_event_two,
  output var  logic                         counter_a_start,
  output var  logic                         counter_a_tick,
  output var  logic                         counter_b_tick,
  output var  logic                         counter_a_clear,
  output var  logic [ertr_pkg::DATA_W-1:0]  a_buffer,
  output var  logic [ertr_pkg::ASW_W-1:0]   bus_addr_sel,
  output var  logic [ertr_pkg::VSW_W-1:0]   vector_sel,
  output var  logic                         irq
);

  localparam int unsigned N  = ertr_pkg::NCHAN;
  localparam int unsigned DW = ertr_pkg::DATA_W;
  localparam int unsigned SW = ertr_pkg::STAT_W;

  // trigger channels
  logic [N-1:0] pin_vec;
  logic [N-1:0] slope_vec;
  logic [N-1:0] edge_vec;

  // alignment
  logic [ertr_pkg::GRID_W-1:0] grid_ff;
  logic [ertr_pkg::GRID_W-1:0] nxt_grid;
  logic                        grid_tick;
  logic [N-1:0]                pend_ff;
  logic [N-1:0]                nxt_pend;
  logic [N-1:0]                bypass;
  logic [N-1:0]                want;
  logic [N-1:0]                release_vec;
  logic [N-1:0]                aligned_ff;

  // registers
  ertr_pkg::ertr_ctrl_type ctrl_ff;
  logic [SW-1:0]           stat_ff;
  logic [SW-1:0]           nxt_stat;
  logic [SW-1:0]           mask_ff;
  logic [SW-1:0]           stat_set;
  logic [SW-1:0]           stat_clr;
  logic [DW-1:0]           buf_ff;
  logic [DW-1:0]           rdata_ff;
  logic [DW-1:0]           nxt_rdata;

  // switch and strap synchronisers
  logic [ertr_pkg::SW_W-1:0]  sw_s1_ff;
  logic [ertr_pkg::SW_W-1:0]  sw_s2_ff;
  logic [ertr_pkg::ASW_W-1:0] addr_sel_ff;
  logic [ertr_pkg::VSW_W-1:0] vec_sel_ff;
  logic                       strap_ff;

  // decoded actions
  logic         ev_one;
  logic         ev_two;
  logic         ev_three;
  logic         ext_mode;
  logic         zero_mode;
  logic         a_start_ff;
  logic         a_tick_ff;
  logic         b_tick_ff;
  logic         a_clear_ff;
  logic         sync_one_ff;
  logic         sync_two_ff;
  logic         irq_ff;
  logic         mode_set;
  logic         ovf_set;
  logic         do_capture;

  // bus decode
  logic         hit_ctrl;
  logic         hit_stat;
  logic         hit_mask;
  logic         hit_buf;
  logic         hit_sw;
  logic [DW-1:0] ctrl_word;
  logic [DW-1:0] sw_word;

  assign pin_vec   = {event_input_three, event_input_two, event_input_one};
  assign slope_vec = {slope_three, slope_two, slope_one};

  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_chan
      ertr_edge_chan u_chan (
        .mclk       (mclk),
        .nrst       (nrst),
        .trig_pin   (pin_vec[gi]),
        .slope_pin  (slope_vec[gi]),
        .edge_pulse (edge_vec[gi])
      );
    end
  endgenerate

  // raw triggers leave before any alignment, for converters and the like
  assign trig_one_out   = event_input_one;
  assign trig_three_out = event_input_three;

  // 1 us grid; auto-increment skips the grid so channel one lands on
  // the next mclk edge, the finest step this clock can offer
  assign grid_tick = (grid_ff == ertr_pkg::GRID_LAST);
  assign nxt_grid  = grid_tick ? '0 : grid_ff + 1'b1;

  assign bypass[ertr_pkg::CH_ONE]   = ctrl_ff.auto_inc;
  assign bypass[ertr_pkg::CH_TWO]   = 1'b0;
  assign bypass[ertr_pkg::CH_THREE] = 1'b1;

  assign want        = pend_ff | edge_vec;
  assign release_vec = want & ({N{grid_tick}} | bypass);
  // a second edge inside one grid period merges with the first
  assign nxt_pend    = want & ~release_vec;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      grid_ff    <= '0;
      pend_ff    <= '0;
      aligned_ff <= '0;
    end else begin
      grid_ff    <= nxt_grid;
      pend_ff    <= nxt_pend;
      aligned_ff <= release_vec;
    end
  end

  assign ev_one   = aligned_ff[ertr_pkg::CH_ONE];
  assign ev_two   = aligned_ff[ertr_pkg::CH_TWO];
  assign ev_three = aligned_ff[ertr_pkg::CH_THREE];

  assign ext_mode  = (ctrl_ff.mode == ertr_pkg::ERTR_MODE_EXT_TIME) ||
                     (ctrl_ff.mode == ertr_pkg::ERTR_MODE_EXT_ZERO);
  assign zero_mode = (ctrl_ff.mode == ertr_pkg::ERTR_MODE_EXT_ZERO);
  assign do_capture = ev_two & ext_mode;

  // mode flag: overflow in interval modes, channel two in timing modes
  assign mode_set = do_capture | (counter_a_ovf & ~ext_mode);
  // without the strap overflow stays legacy: no own flag or interrupt
  assign ovf_set  = counter_a_ovf & strap_ff;

  always_comb begin
    stat_set                    = '0;
    stat_set[ertr_pkg::ST_ONE]   = ev_one;
    stat_set[ertr_pkg::ST_MODE]  = mode_set;
    stat_set[ertr_pkg::ST_AOVF]  = ovf_set;
    stat_set[ertr_pkg::ST_TWO]   = ev_two;
    stat_set[ertr_pkg::ST_THREE] = ev_three;
  end

  // a set arriving with its clear wins, so no event is lost
  assign stat_clr = (bus_req.wr && hit_stat) ? bus_req.wdata[SW-1:0] : '0;
  assign nxt_stat = (stat_ff & ~stat_clr) | stat_set;

  // action pulses toward the counter cores
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      a_start_ff  <= 1'b0;
      a_tick_ff   <= 1'b0;
      b_tick_ff   <= 1'b0;
      a_clear_ff  <= 1'b0;
      sync_one_ff <= 1'b0;
      sync_two_ff <= 1'b0;
    end else begin
      a_start_ff  <= ev_one & ctrl_ff.start_on_trig;
      a_tick_ff   <= ev_one & (ctrl_ff.rate_a == ertr_pkg::RATE_EXT);
      b_tick_ff   <= ev_three & (ctrl_ff.rate_b == ertr_pkg::RATE_EXT);
      a_clear_ff  <= do_capture & zero_mode;
      sync_one_ff <= ev_one;
      sync_two_ff <= ev_two;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      buf_ff <= '0;
    end else if (do_capture) begin
      buf_ff <= counter_a_value;
    end
  end

  // switches: on means address zero but vector one
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sw_s1_ff    <= '0;
      sw_s2_ff    <= '0;
      addr_sel_ff <= '0;
      vec_sel_ff  <= '0;
      strap_ff    <= 1'b0;
    end else begin
      sw_s1_ff    <= {overflow_irq_all_modes_strap, vec_switch_on,
                      addr_switch_on};
      sw_s2_ff    <= sw_s1_ff;
      addr_sel_ff <= ~sw_s2_ff[ertr_pkg::ASW_W-1:0];
      vec_sel_ff  <= sw_s2_ff[ertr_pkg::ASW_W +: ertr_pkg::VSW_W];
      strap_ff    <= sw_s2_ff[ertr_pkg::SW_W-1];
    end
  end

  // register port
  assign hit_ctrl = (bus_req.addr == ertr_pkg::REG_CTRL);
  assign hit_stat = (bus_req.addr == ertr_pkg::REG_STAT);
  assign hit_mask = (bus_req.addr == ertr_pkg::REG_MASK);
  assign hit_buf  = (bus_req.addr == ertr_pkg::REG_BUF);
  assign hit_sw   = (bus_req.addr == ertr_pkg::REG_SW);

  assign ctrl_word = ctrl_ff;
  assign sw_word   = {{(DW - ertr_pkg::SW_W){1'b0}}, strap_ff,
                      vec_sel_ff, addr_sel_ff};

  always_comb begin
    if (hit_ctrl) begin
      nxt_rdata = ctrl_word;
    end else if (hit_stat) begin
      nxt_rdata = {{(DW - SW){1'b0}}, stat_ff};
    end else if (hit_mask) begin
      nxt_rdata = {{(DW - SW){1'b0}}, mask_ff};
    end else if (hit_buf) begin
      nxt_rdata = buf_ff;
    end else if (hit_sw) begin
      nxt_rdata = sw_word;
    end else begin
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_ff <= ertr_pkg::CTRL_RST;
      mask_ff <= ertr_pkg::MASK_RST;
    end else if (bus_req.wr) begin
      if (hit_ctrl) begin
        ctrl_ff <= bus_req.wdata;
      end
      if (hit_mask) begin
        mask_ff <= bus_req.wdata[SW-1:0];
      end
    end
  end

  // read data only stand in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else if (bus_req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stat_ff <= ertr_pkg::STAT_RST;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff  <= |(nxt_stat & mask_ff);
    end
  end

  assign bus_rdata        = rdata_ff;
  assign synced_event_one = sync_one_ff;
  assign synced_event_two = sync_two_ff;
  assign counter_a_start  = a_start_ff;
  assign counter_a_tick   = a_tick_ff;
  assign counter_b_tick   = b_tick_ff;
  assign counter_a_clear  = a_clear_ff;
  assign a_buffer         = buf_ff;
  assign bus_addr_sel     = addr_sel_ff;
  assign vector_sel       = vec_sel_ff;
  assign irq              = irq_ff;

endmodule

`default_nettype wire

// ==== sim/ertr_core_asserts.sv ====
// Purpose: port-level checks of the trigger routing core
// Assumes: one clock domain, synchronous active-low reset
// Notes:   only ports are visible, so mode effects are inferred
`timescale 1ns/100ps
`default_nettype none
module ertr_core_asserts (
  input wire logic                        mclk,
  input wire logic                        nrst,
  input wire logic                        event_input_one,
  input wire logic                        trig_one_out,
  input wire logic [ertr_pkg::ASW_W-1:0]  addr_switch_on,
  input wire logic [ertr_pkg::ASW_W-1:0]  bus_addr_sel,
  input wire logic [ertr_pkg::DATA_W-1:0] counter_a_value,
  input wire logic [ertr_pkg::DATA_W-1:0] a_buffer,
  input wire logic                        synced_event_one,
  input wire logic                        synced_event_two,
  input wire logic                        counter_a_start,
  input wire logic                        counter_a_tick,
  input wire logic                        counter_a_clear
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // five quiet cycles cover the switch synchronisers
  sequence s_sw_quiet;
    $stable(addr_switch_on) [*5];
  endsequence
  // aligned events cannot come closer than one grid period
  sequence s_grid_gap;
    (!synced_event_two) [*8] ##1 !synced_event_two;
  endsequence
  property p_raw_one;
    trig_one_out == event_input_one;
  endproperty
  property p_addr_sel;
    s_sw_quiet |-> bus_addr_sel == ~addr_switch_on;
  endproperty
  property p_pulse_one;
    synced_event_one |=> !synced_event_one;
  endproperty
  property p_gap_two;
    synced_event_two |=> s_grid_gap;
  endproperty
  property p_cap;
    counter_a_clear |-> a_buffer == $past(counter_a_value);
  endproperty
  property p_buf_cause;
    $changed(a_buffer) |-> synced_event_two;
  endproperty
  property p_start;
    counter_a_start |-> synced_event_one;
  endproperty
  property p_tick;
    counter_a_tick |-> synced_event_one;
  endproperty
  a_raw_one: assert property (p_raw_one)
    else $error("raw trigger one differs from pin");
  a_addr_sel: assert property (p_addr_sel)
    else $error("address select not inverted switches");
  a_pulse_one: assert property (p_pulse_one)
    else $error("synced event one longer than a cycle");
  a_gap_two: assert property (p_gap_two)
    else $error("synced event two off the grid");
  a_cap: assert property (p_cap)
    else $error("clear without capture of counter");
  a_buf_cause: assert property (p_buf_cause)
    else $error("buffer changed without event two");
  a_start: assert property (p_start)
    else $error("start without synced event one");
  a_tick: assert property (p_tick)
    else $error("tick without synced event one");
endmodule
bind ertr_core ertr_core_asserts u_chk (.mclk(mclk), .nrst(nrst),
  .event_input_one(event_input_one), .trig_one_out(trig_one_out),
  .addr_switch_on(addr_switch_on), .bus_addr_sel(bus_addr_sel),
  .counter_a_value(counter_a_value), .a_buffer(a_buffer),
  .synced_event_one(synced_event_one), .synced_event_two(synced_event_two),
  .counter_a_start(counter_a_start), .counter_a_tick(counter_a_tick),
  .counter_a_clear(counter_a_clear));
`default_nettype wire

// ==== sim/ertr_ext_model.sv ====
// Purpose: far side: trigger sources, slope lines and counter A core
// Assumes: tasks are called from the bench between clock edges
// Notes:   counter free-runs so every capture sees a moving value
`timescale 1ns/100ps
`default_nettype none
module ertr_ext_model (
  input  wire logic                        mclk,
  input  wire logic                        nrst,
  input  wire logic                        counter_a_clear,
  output var  logic [ertr_pkg::DATA_W-1:0] counter_a_value,
  output var  logic                        event_input_one,
  output var  logic                        event_input_two,
  output var  logic                        event_input_three,
  output var  logic                        slope_one,
  output var  logic                        slope_two,
  output var  logic                        slope_three
);
  logic [2:0] pin_ff = 3'h0;
  logic [2:0] slope_ff = 3'h0;
  assign {event_input_three, event_input_two, event_input_one} = pin_ff;
  assign {slope_three, slope_two, slope_one} = slope_ff;
  // grounded slope selects the rise, open slope the fall
  task automatic set_pins(input logic [2:0] p, input logic [2:0] s);
    @(posedge mclk);
    pin_ff <= p;
    slope_ff <= s;
  endtask
  always_ff @(posedge mclk) begin
    if (!nrst || counter_a_clear) begin
      counter_a_value <= 16'h0000;
    end else begin
      counter_a_value <= counter_a_value + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== sim/test_external_event_trigger_routing.sv ====
// Purpose: self-checking bench for the trigger routing core
// Assumes: 10 MHz mclk, far side modelled by ertr_ext_model
// Notes:   grid is ten cycles, so event waits are bounded at 30
`timescale 1ns/100ps
`default_nettype none
module test_external_event_trigger_routing;
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rst_val;
    logic [15:0] exp_val;
  } ertr_row_type;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic counter_a_ovf = 1'b0;
  logic overflow_irq_all_modes_strap = 1'b1;
  logic [7:0] addr_switch_on = 8'h0f;
  logic [4:0] vec_switch_on = 5'h05;
  ertr_pkg::ertr_bus_req_type bus_req = '0;
  logic event_input_one, event_input_two, event_input_three, irq;
  logic slope_one, slope_two, slope_three, trig_one_out;
  logic trig_three_out, synced_event_one, synced_event_two;
  logic counter_a_start, counter_a_tick, counter_b_tick, counter_a_clear;
  logic [7:0] bus_addr_sel;
  logic [4:0] vector_sel;
  logic [15:0] bus_rdata, counter_a_value, a_buffer, rd_val, prev;
  int bad_count = 0;
  int tests_run = 0;
  int lat;
  ertr_row_type rows [6];

  ertr_core DUT (
    .mclk(mclk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .event_input_one(event_input_one), .event_input_two(event_input_two),
    .event_input_three(event_input_three), .slope_one(slope_one),
    .slope_two(slope_two), .slope_three(slope_three),
    .addr_switch_on(addr_switch_on), .vec_switch_on(vec_switch_on),
    .overflow_irq_all_modes_strap(overflow_irq_all_modes_strap),
    .counter_a_value(counter_a_value), .counter_a_ovf(counter_a_ovf),
    .trig_one_out(trig_one_out), .trig_three_out(trig_three_out),
    .synced_event_one(synced_event_one),
    .synced_event_two(synced_event_two),
    .counter_a_start(counter_a_start), .counter_a_tick(counter_a_tick),
    .counter_b_tick(counter_b_tick), .counter_a_clear(counter_a_clear),
    .a_buffer(a_buffer), .bus_addr_sel(bus_addr_sel),
    .vector_sel(vector_sel), .irq(irq)
  );
  ertr_ext_model u_src (
    .mclk(mclk), .nrst(nrst), .counter_a_clear(counter_a_clear),
    .counter_a_value(counter_a_value), .event_input_one(event_input_one),
    .event_input_two(event_input_two),
    .event_input_three(event_input_three), .slope_one(slope_one),
    .slope_two(slope_two), .slope_three(slope_three)
  );

  always #50 mclk = ~mclk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  function automatic logic outsig(input int ch);
    return ch == 0 ? synced_event_one :
           ch == 1 ? synced_event_two : counter_b_tick;
  endfunction
  // prev keeps the counter value seen just before the event edge
  task automatic wait_ev(input int ch);
    lat = 0;
    do begin
      prev = counter_a_value;
      @(posedge mclk);
      #1 lat++;
    end while (outsig(ch) !== 1'b1 && lat < 30);
  endtask
  task automatic ovf_case(input logic s, input logic [15:0] c,
                          input logic [15:0] e);
    overflow_irq_all_modes_strap <= s;
    bus_wr(3'h0, c);
    repeat (5) @(posedge mclk);
    bus_wr(3'h1, 16'h001f);
    counter_a_ovf <= 1'b1;
    @(posedge mclk);
    counter_a_ovf <= 1'b0;
    bus_rd(3'h1, rd_val);
    chk(rd_val, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    rows[0] = '{3'h0, 16'h2345, 16'h0000, 16'h2345};
    rows[1] = '{3'h2, 16'hffff, 16'h0000, 16'h001f};
    rows[2] = '{3'h1, 16'hffff, 16'h0000, 16'h0000};
    rows[3] = '{3'h3, 16'hffff, 16'h0000, 16'h0000};
    rows[4] = '{3'h4, 16'hffff, 16'h25f0, 16'h25f0};
    rows[5] = '{3'h5, 16'hffff, 16'h0000, 16'h0000};
    repeat (10) @(posedge mclk);
    chk({13'h0, irq, synced_event_one, counter_a_start}, 16'h0000);
    nrst <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      bus_rd(rows[i].addr, rd_val);
      chk(rd_val, rows[i].rst_val);
      bus_wr(rows[i].addr, rows[i].wdata);
      bus_rd(rows[i].addr, rd_val);
      chk(rd_val, rows[i].exp_val);
    end
    chk({3'h0, vector_sel, bus_addr_sel}, 16'h05f0);
    $display("test registers done");
    // falling edge on one starts and ticks counter A
    bus_wr(3'h2, 16'h0001);
    bus_wr(3'h0, 16'h2018);
    u_src.set_pins(3'h1, 3'h1);
    repeat (12) @(posedge mclk);
    bus_wr(3'h1, 16'h001f);
    u_src.set_pins(3'h0, 3'h1);
    wait_ev(0);
    chk({12'h0, irq, counter_a_start, counter_a_tick, synced_event_one},
        16'h000f);
    @(posedge mclk);
    #1 chk({15'h0, synced_event_one}, 16'h0000);
    bus_rd(3'h1, rd_val);
    chk(rd_val, 16'h0001);
    u_src.set_pins(3'h1, 3'h1);
    wait_ev(0);
    chk({8'h0, lat[7:0]}, 16'h001e);
    chk({15'h0, trig_one_out}, 16'h0001);
    $display("test channel one done");
    // auto increment skips the grid wait
    bus_wr(3'h0, 16'h0100);
    u_src.set_pins(3'h0, 3'h0);
    repeat (12) @(posedge mclk);
    u_src.set_pins(3'h1, 3'h0);
    wait_ev(0);
    chk({15'h0, lat < 7}, 16'h0001);
    $display("test auto increment done");
    // mode three: capture, clear and mode flag interrupt
    bus_wr(3'h0, 16'h0003);
    bus_wr(3'h2, 16'h0002);
    bus_wr(3'h1, 16'h001f);
    u_src.set_pins(3'h3, 3'h0);
    wait_ev(1);
    chk(a_buffer, prev);
    chk({13'h0, counter_a_clear, irq, synced_event_two},
        16'h0007);
    bus_rd(3'h1, rd_val);
    chk(rd_val, 16'h000a);
    bus_wr(3'h1, 16'h000a);
    bus_rd(3'h1, rd_val);
    chk({irq, rd_val[14:0]}, 16'h0000);
    // mode two captures but leaves counter A running
    bus_wr(3'h0, 16'h0002);
    u_src.set_pins(3'h1, 3'h0);
    repeat (4) @(posedge mclk);
    u_src.set_pins(3'h3, 3'h0);
    wait_ev(1);
    chk(a_buffer, prev);
    chk({15'h0, counter_a_clear}, 16'h0000);
    $display("test channel two done");
    bus_wr(3'h0, 16'h00c0);
    u_src.set_pins(3'h7, 3'h0);
    wait_ev(2);
    chk({14'h0, trig_three_out, counter_b_tick}, 16'h0003);
    $display("test channel three done");
    ovf_case(1'b1, 16'h0002, 16'h0004);
    ovf_case(1'b0, 16'h0000, 16'h0002);
    $display("test overflow done");
    // pins sit high through a reset: no false edge on release
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (20) @(posedge mclk);
    bus_rd(3'h1, rd_val);
    chk(rd_val, 16'h0000);
    bus_rd(3'h0, rd_val);
    chk(rd_val, 16'h0000);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
